// ===== inc/hbsp_map.svh
// constants of the half-bridge serial command port
`ifndef HBSP_MAP_SVH
`define HBSP_MAP_SVH
`define HBSP_CLK_MHZ     100
`define HBSP_FRAME_BITS  16
`define HBSP_GROUP_BITS  8
`define HBSP_BRIDGES     6
`define HBSP_POR_US      100
`define HBSP_SRR_US      150
`define HBSP_DEAD_NS     1500
`define HBSP_CTRL_RESET  16'h0000
`define HBSP_DIAG_RESET  16'h0000
`endif

// ===== inc/hbsp_pkg.sv
// types shared by the half-bridge serial command port
package hbsp_pkg;
	// command word, bit 15 first
	typedef struct packed {
		logic       fault_clear_request;
		logic       bridge_group_select;
		logic       underload_shutdown_enable;
		logic [5:0] bridge_output_enable;
		logic [5:0] bridge_side_select;
		logic       overvoltage_lockout_enable;
	} hbsp_ctrl_t;
	// diagnostic word, bit 15 first
	typedef struct packed {
		logic       overcurrent_shutdown_flag;
		logic       supply_failure_flag;
		logic       underload_flag;
		logic [5:0] bridge_enable_report;
		logic [5:0] bridge_side_report;
		logic       thermal_warning_flag;
	} hbsp_diag_t;
	// analog fault events into the logic
	typedef struct packed {
		logic       thermal_shutdown;
		logic       overcurrent;
		logic       supply_failure;
		logic       thermal_warning;
		logic [5:0] underload;
	} hbsp_fault_t;
	typedef enum logic [1:0] {
		hbsp_off,
		hbsp_por,
		hbsp_run
	} hbsp_state_t;
endpackage

// ===== verilog/hbsp_bridge_gate.sv
// non-overlapping high/low side gate control for the half bridges
`timescale 1ns/1ps
`include "hbsp_map.svh"
module hbsp_bridge_gate #(
	parameter int N    = `HBSP_BRIDGES,
	parameter int DEAD = 150
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [N-1:0] want_high,
	input  wire logic [N-1:0] want_low,
	output logic      [N-1:0] high_on,
	output logic      [N-1:0] low_on
);
	localparam int CW = $clog2(DEAD + 1);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_br
			logic [CW-1:0] dead;
			logic          hi;
			logic          lo;
			wire           drop = (hi & ~want_high[i]) | (lo & ~want_low[i]);
			// one register pair per bridge, so no output vector has several writers
			always_ff @(posedge clock) begin
				if (rst) begin
					hi   <= 1'b0;
					lo   <= 1'b0;
					dead <= '0;
				end else if (drop) begin
					// both sides off first, then wait out the dead time
					hi   <= 1'b0; // R19
					lo   <= 1'b0;
					dead <= CW'(DEAD);
				end else if (dead != '0) begin
					dead <= dead - 1'b1;
				end else begin
					hi <= want_high[i] & ~want_low[i]; // R19
					lo <= want_low[i] & ~want_high[i];
				end
			end
			assign high_on[i] = hi;
			assign low_on[i]  = lo;
			property p_no_shoot;
				@(posedge clock) disable iff (rst) !(high_on[i] && low_on[i]);
			endproperty
			a_no_shoot: assert property (p_no_shoot) else $error("both sides on"); // R19
			property p_gap_high;
				@(posedge clock) disable iff (rst) $fell(low_on[i]) |-> !high_on[i] [*8];
			endproperty
			a_gap_high: assert property (p_gap_high) else $error("no dead time"); // R19
		end
	endgenerate
endmodule

// ===== verilog/hbsp_command_port.sv
// serial command and diagnostic port of the six half-bridge driver
//
// Function
// (R1) enable low clears everything, drivers off
// (R2) enable high runs power-on delay, then operation
// (R3) serial transfers only honoured while enabled
// (R4) full duplex 16-bit frames plus pre bit
// (R5) master holds data and clock low first
// (R6) msb first, input sampled on falling clock
// (R7) previous diagnostics shifted out on rising clock
// (R8) at least sixteen bits counted per frame
// (R9) extra bits only in whole groups of eight
// (R10) chip select rise commits last sixteen bits
// (R11) serial output released while chip select high
// (R12) bit 15 set clears latched faults
// (R13) bit 14 reserved, master writes zero
// (R14) bit 13 enables per-bridge under-load shutdown
// (R15) bits 12..7 enable bridges 6..1
// (R16) bits 6..1 pick high or low side
// (R17) bit 0 enables over-voltage lockout
// (R18) thermal shutdown bit shown before first rise
// (R19) never both sides on, dead time inserted
// (R20) diagnostic word layout fixed
// (R21) too-close fault clear requests are ignored
// (R22) command word zero after enable reset
`timescale 1ns/1ps
`include "hbsp_map.svh"
module hbsp_command_port #(
	parameter int POR_CYCLES = `HBSP_POR_US * `HBSP_CLK_MHZ,
	parameter int SRR_CYCLES = `HBSP_SRR_US * `HBSP_CLK_MHZ
) (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic                  enable,
	input  wire logic                  chip_select_low,
	input  wire logic                  shift_clock,
	input  wire logic                  serial_in,
	output logic                       serial_out,
	output logic                       serial_out_oe,
	input  wire hbsp_pkg::hbsp_fault_t fault_event,
	output logic [`HBSP_BRIDGES-1:0]   high_side_on,
	output logic [`HBSP_BRIDGES-1:0]   low_side_on,
	output logic                       overvoltage_lockout_enable,
	output logic                       thermal_shutdown_latched,
	output logic                       logic_ready
);
	localparam int DEAD_CYCLES = (`HBSP_DEAD_NS * `HBSP_CLK_MHZ + 999) / 1000;
	localparam int FB = `HBSP_FRAME_BITS;

	// ==========================================================
	// pin synchronisers
	logic [1:0] en_sync;
	logic [1:0] cs_sync;
	logic [1:0] sck_sync;
	logic [1:0] si_sync;
	logic       cs_prev;
	logic       sck_prev;
	always_ff @(posedge clock) begin
		if (rst) begin
			en_sync  <= 2'h0;
			cs_sync  <= 2'h3;
			sck_sync <= 2'h0;
			si_sync  <= 2'h0;
			cs_prev  <= 1'b1;
			sck_prev <= 1'b0;
		end else begin
			en_sync  <= {en_sync[0], enable};
			cs_sync  <= {cs_sync[0], chip_select_low};
			sck_sync <= {sck_sync[0], shift_clock};
			si_sync  <= {si_sync[0], serial_in};
			cs_prev  <= cs_sync[1];
			sck_prev <= sck_sync[1];
		end
	end
	wire en_s     = en_sync[1];
	wire cs_s     = cs_sync[1];
	wire si_s     = si_sync[1];
	wire cs_fall  = cs_prev & ~cs_s;
	wire cs_rise  = ~cs_prev & cs_s;
	wire sck_rise = ~sck_prev & sck_sync[1] & ~cs_s;
	wire sck_fall = sck_prev & ~sck_sync[1] & ~cs_s;

	// ==========================================================
	// enable and power-on sequence
	// a low enable acts as a reset of all the logic below
	wire                  clr = rst | ~en_s; // R1
	hbsp_pkg::hbsp_state_t state;
	hbsp_pkg::hbsp_state_t next_state;
	int unsigned          por_cnt;
	always_comb begin
		next_state = state;
		case (state)
			hbsp_pkg::hbsp_off: next_state = hbsp_pkg::hbsp_por;
			hbsp_pkg::hbsp_por: if (por_cnt == 0) next_state = hbsp_pkg::hbsp_run; // R2
			hbsp_pkg::hbsp_run: next_state = hbsp_pkg::hbsp_run;
			default:            next_state = hbsp_pkg::hbsp_off;
		endcase
	end
	always_ff @(posedge clock) begin
		if (clr) begin
			state   <= hbsp_pkg::hbsp_off;
			por_cnt <= POR_CYCLES;
		end else begin
			state <= next_state;
			if (state == hbsp_pkg::hbsp_por && por_cnt != 0)
				por_cnt <= por_cnt - 1;
		end
	end
	assign logic_ready = (state == hbsp_pkg::hbsp_run);
	// a frame counts only if it started after the port became ready
	logic frame_open;
	wire  active = logic_ready & frame_open; // R3

	// ==========================================================
	// frame reception
	logic [FB-1:0] rx_shift;
	logic [15:0]   bit_cnt;
	function automatic logic frame_valid(input logic [15:0] n);
		frame_valid = (n >= 16'(FB)) && (n[2:0] == 3'h0); // R8 R9
	endfunction
	wire frame_ok = frame_valid(bit_cnt);
	always_ff @(posedge clock) begin
		if (clr) begin
			rx_shift   <= '0;
			bit_cnt    <= 16'h0000;
			frame_open <= 1'b0;
		end else begin
			if (cs_fall) begin
				bit_cnt    <= 16'h0000;
				frame_open <= logic_ready;
			end else if (cs_rise) begin
				frame_open <= 1'b0;
			end
			if (sck_fall && active) begin
				rx_shift <= {rx_shift[FB-2:0], si_s}; // R6
				if (bit_cnt != 16'hffff)
					bit_cnt <= bit_cnt + 16'h0001; // R8
			end
		end
	end

	// ==========================================================
	// command word and fault clear spacing
	hbsp_pkg::hbsp_ctrl_t ctrl;
	int unsigned          srr_gap;
	wire                  commit    = cs_rise & active & frame_ok; // R10
	wire                  req_clear = commit & rx_shift[FB-1];
	wire                  clear_ok  = req_clear & (srr_gap == 0); // R21
	always_ff @(posedge clock) begin
		if (clr) begin
			ctrl    <= `HBSP_CTRL_RESET; // R22
			srr_gap <= 0;
		end else begin
			if (commit)
				ctrl <= rx_shift; // R10
			if (req_clear)
				srr_gap <= SRR_CYCLES; // R21
			else if (srr_gap != 0)
				srr_gap <= srr_gap - 1;
		end
	end
	assign overvoltage_lockout_enable = ctrl.overvoltage_lockout_enable; // R17

	// ==========================================================
	// latched faults; a new event beats a clear in the same cycle
	logic                     ocs_latched;
	logic [`HBSP_BRIDGES-1:0] uld_latched;
	always_ff @(posedge clock) begin
		if (clr) begin
			thermal_shutdown_latched <= 1'b0;
			ocs_latched              <= 1'b0;
			uld_latched              <= '0;
		end else begin
			thermal_shutdown_latched <= fault_event.thermal_shutdown |
				(thermal_shutdown_latched & ~clear_ok); // R12
			ocs_latched <= fault_event.overcurrent | (ocs_latched & ~clear_ok); // R12
			uld_latched <= fault_event.underload |
				(uld_latched & ~{`HBSP_BRIDGES{clear_ok}}); // R12
		end
	end

	// ==========================================================
	// bridge drive
	wire                      global_off = ~logic_ready | thermal_shutdown_latched |
		ocs_latched | (fault_event.supply_failure & ctrl.overvoltage_lockout_enable); // R17
	wire [`HBSP_BRIDGES-1:0]  uld_off = uld_latched &
		{`HBSP_BRIDGES{ctrl.underload_shutdown_enable}}; // R14
	wire [`HBSP_BRIDGES-1:0]  drive_on = ctrl.bridge_output_enable & ~uld_off &
		~{`HBSP_BRIDGES{global_off}}; // R15
	wire [`HBSP_BRIDGES-1:0]  want_high = drive_on & ctrl.bridge_side_select; // R16
	wire [`HBSP_BRIDGES-1:0]  want_low = drive_on & ~ctrl.bridge_side_select; // R16
	hbsp_bridge_gate #(
		.N    (`HBSP_BRIDGES),
		.DEAD (DEAD_CYCLES)
	) u_gate (
		.clock     (clock),
		.rst       (clr),
		.want_high (want_high),
		.want_low  (want_low),
		.high_on   (high_side_on),
		.low_on    (low_side_on)
	);

	// ==========================================================
	// diagnostic output
	hbsp_pkg::hbsp_diag_t diag;
	assign diag = {ocs_latched, fault_event.supply_failure, |uld_latched,
		ctrl.bridge_output_enable, ctrl.bridge_side_select,
		fault_event.thermal_warning}; // R20
	// slot 0 refills with the input bit, so data passes on after 16 clocks
	logic [FB-1:0] tx_shift;
	logic          so_bit;
	always_ff @(posedge clock) begin
		if (clr) begin
			tx_shift <= `HBSP_DIAG_RESET;
			so_bit   <= 1'b0;
		end else if (cs_fall) begin
			tx_shift <= diag; // R7
			so_bit   <= thermal_shutdown_latched; // R18
		end else if (sck_rise && active) begin
			so_bit   <= tx_shift[FB-1]; // R7
			tx_shift <= {tx_shift[FB-2:0], 1'b0};
		end else if (sck_fall && active) begin
			tx_shift[0] <= si_s; // R4
		end else if (cs_s) begin
			so_bit <= 1'b0;
		end
	end
	assign serial_out    = so_bit;
	assign serial_out_oe = ~cs_s & logic_ready; // R11

	// ==========================================================
	// checks
	property p_so_released;
		@(posedge clock) disable iff (rst) cs_s |-> !serial_out_oe;
	endproperty
	a_so_released: assert property (p_so_released) else $error("output driven"); // R11
	property p_disable_clears;
		@(posedge clock) disable iff (rst) !en_s |=> ctrl == 16'h0000 && !logic_ready;
	endproperty
	a_disable_clears: assert property (p_disable_clears) else $error("not cleared"); // R1
	property p_por_wait;
		@(posedge clock) disable iff (rst) $rose(en_s) |=> !logic_ready [*8];
	endproperty
	a_por_wait: assert property (p_por_wait) else $error("ready too early"); // R2
	property p_commit;
		@(posedge clock) disable iff (clr) commit |=> ctrl == $past(rx_shift);
	endproperty
	a_commit: assert property (p_commit) else $error("frame not taken"); // R10
	property p_discard;
		@(posedge clock) disable iff (clr) cs_rise && !frame_ok |=> $stable(ctrl);
	endproperty
	a_discard: assert property (p_discard) else $error("bad frame taken"); // R9
	property p_short;
		@(posedge clock) disable iff (clr) bit_cnt < 16'h0010 |-> !frame_ok;
	endproperty
	a_short: assert property (p_short) else $error("short frame ok"); // R8
	property p_pre_bit;
		@(posedge clock) disable iff (clr)
			cs_fall |=> serial_out == $past(thermal_shutdown_latched);
	endproperty
	a_pre_bit: assert property (p_pre_bit) else $error("pre bit wrong"); // R18
	property p_sample;
		@(posedge clock) disable iff (clr) sck_fall && active |=> rx_shift[0] == $past(si_s);
	endproperty
	a_sample: assert property (p_sample) else $error("input bit lost"); // R6
	property p_clear;
		@(posedge clock) disable iff (clr)
			clear_ok && !fault_event.overcurrent |=> !ocs_latched;
	endproperty
	a_clear: assert property (p_clear) else $error("fault not cleared"); // R12
	property p_spacing;
		@(posedge clock) disable iff (clr) req_clear |=> !clear_ok [*8];
	endproperty
	a_spacing: assert property (p_spacing) else $error("clear too close"); // R21
endmodule

// ===== tb/hbsp_spi_master.sv
// shift master model that drives the command port pins
`timescale 1ns/1ps
// ==========================================
// master model
module hbsp_spi_master (
	input  wire logic clock,
	output logic      chip_select_low,
	output logic      shift_clock,
	output logic      serial_in,
	input  wire logic serial_out
);
	initial begin
		chip_select_low = 1'b1;
		shift_clock = 1'b0;
		serial_in = 1'b0;
	end
	// got collects the pre bit, then one bit after every rising shift edge
	task automatic frame(input logic [31:0] data, input int n, output logic [32:0] got);
		got = '0;
		@(negedge clock);
		chip_select_low = 1'b0;
		repeat (8) @(negedge clock);
		for (int i = n - 1; i >= 0; i--) begin
			got = {got[31:0], serial_out};
			serial_in = data[i];
			shift_clock = 1'b1;
			repeat (4) @(negedge clock);
			shift_clock = 1'b0;
			repeat (4) @(negedge clock);
		end
		got = {got[31:0], serial_out};
		// data line is driven low again in the same time step as chip select rises
		serial_in = 1'b0;
		chip_select_low = 1'b1;
		repeat (8) @(negedge clock);
	endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench of the half-bridge serial command port
`timescale 1ns/1ps
module tb_top;
	// ==========================================
	// signals
	localparam int POR = 20;
	localparam int FAULT_CLEAR_REQUEST = 400;
	logic                  clock = 1'b0;
	logic                  rst = 1'b1;
	logic                  enable = 1'b1;
	logic                  chip_select_low;
	logic                  shift_clock;
	logic                  serial_in;
	logic                  serial_out;
	logic                  serial_out_oe;
	hbsp_pkg::hbsp_fault_t fault_event = '0;
	logic [5:0]            high_side_on;
	logic [5:0]            low_side_on;
	logic                  overvoltage_lockout_enable;
	logic                  thermal_shutdown_latched;
	logic                  logic_ready;
	logic [32:0]           got;
	int                    fail_count = 0;
	int                    samples_checked = 0;
	int                    cycles = 0;
	int                    oe_cycles = 0;
	always #5 clock = ~clock;
	// counts clocks on which the port drives its serial output
	always @(posedge clock)
		if (serial_out_oe === 1'b1) oe_cycles <= oe_cycles + 1;
	hbsp_command_port #(.POR_CYCLES(POR), .SRR_CYCLES(FAULT_CLEAR_REQUEST)) dut (
		.clock(clock), .rst(rst), .enable(enable), .chip_select_low(chip_select_low),
		.shift_clock(shift_clock), .serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .fault_event(fault_event),
		.high_side_on(high_side_on), .low_side_on(low_side_on),
		.overvoltage_lockout_enable(overvoltage_lockout_enable),
		.thermal_shutdown_latched(thermal_shutdown_latched), .logic_ready(logic_ready));
	hbsp_spi_master m (.clock(clock), .chip_select_low(chip_select_low),
		.shift_clock(shift_clock), .serial_in(serial_in), .serial_out(serial_out));
	// ==========================================
	// helpers
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// generous ceiling: the whole sequence needs well under 10000 cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task automatic idle(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic pulse(input logic [9:0] f);
		fault_event = hbsp_pkg::hbsp_fault_t'(f);
		idle(3);
		fault_event = '0;
		idle(3);
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		while (logic_ready !== 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		check("por time", (n >= POR) && (n <= POR + 4), 1);
	endtask
	task automatic drives(input logic [5:0] hi, input logic [5:0] lo);
		check("high side", high_side_on, hi);
		check("low side", low_side_on, lo);
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset();
		int oe0;
		drives(6'h00, 6'h00);
		check("overvoltage_lockout_enable", overvoltage_lockout_enable, 0);
		oe0 = oe_cycles;
		m.frame(32'h0, 16, got);
		// chip select is low for 8 lead clocks plus 8 per bit
		check("oe in frame", oe_cycles - oe0, 8 + 16 * 8);
		check("first diag", got[16:0], 0);
		check("oe idle", serial_out_oe, 0);
		check("so idle", serial_out, 0);
	endtask
	task automatic t_drive();
		// bit 14 always written as zero
		m.frame(32'h16cd, 16, got);
		idle(200);
		drives(6'h24, 6'h09);
		check("overvoltage_lockout_enable", overvoltage_lockout_enable, 1);
		fault_event.thermal_warning = 1'b1;
		m.frame(32'h16b3, 16, got);
		fault_event = '0;
		check("echo diag", got[16:0], 17'h16cd);
		idle(10);
		drives(6'h00, 6'h00);
		idle(200);
		drives(6'h09, 6'h24);
	endtask
	task automatic t_frames();
		int bad [3] = '{15, 17, 23};
		foreach (bad[i]) begin
			m.frame(32'h0, bad[i], got);
			idle(200);
			drives(6'h09, 6'h24);
		end
		m.frame(32'h5a1680, 24, got);
		check("daisy out", got[24:0], {1'b0, 16'h16b2, 8'h5a});
		idle(200);
		drives(6'h00, 6'h2d);
	endtask
	task automatic t_faults();
		pulse(10'h301);
		check("tsd latch", thermal_shutdown_latched, 1);
		drives(6'h00, 6'h00);
		m.frame(32'h3680, 16, got);
		check("fault diag", got[16:13], 4'b1101);
		check("no clear", thermal_shutdown_latched, 1);
		m.frame(32'hb680, 16, got);
		check("clear", thermal_shutdown_latched, 0);
		idle(200);
		drives(6'h00, 6'h2d);
		pulse(10'h200);
		m.frame(32'hb680, 16, got);
		check("close clear", thermal_shutdown_latched, 1);
		idle(FAULT_CLEAR_REQUEST + 20);
		m.frame(32'hb680, 16, got);
		check("late clear", thermal_shutdown_latched, 0);
		// under-load on bridge 1 with the shutdown option set
		pulse(10'h001);
		drives(6'h00, 6'h2c);
		m.frame(32'h1681, 16, got);
		fault_event.supply_failure = 1'b1;
		idle(10);
		drives(6'h00, 6'h00);
		fault_event = '0;
		idle(200);
		drives(6'h00, 6'h2d);
	endtask
	task automatic t_enable();
		int oe0;
		enable = 1'b0;
		idle(10);
		check("sleep ready", logic_ready, 0);
		check("sleep oe", serial_out_oe, 0);
		drives(6'h00, 6'h00);
		oe0 = oe_cycles;
		m.frame(32'h16cd, 16, got);
		check("sleep frame oe", oe_cycles - oe0, 0);
		enable = 1'b1;
		wait_ready();
		drives(6'h00, 6'h00);
		check("overvoltage_lockout_enable", overvoltage_lockout_enable, 0);
	endtask
	// ==========================================
	// main sequence
	initial begin
		idle(20);
		rst = 1'b0;
		wait_ready();
		t_reset();
		t_drive();
		t_frames();
		t_faults();
		t_enable();
		report_and_stop();
	end
endmodule
